// ===== common/eecp_pkg.sv
// eecp_pkg: constants shared by the eeprom configuration and protection logic
package eecp_pkg;
    // ==========================================================
    // array geometry
    localparam int ARRAY_BYTES = 512;
    localparam int BLOCK_BYTES = 128;
    localparam int TGT_W = 10;
    localparam logic [TGT_W-1:0] SECURE_LO = 10'h0F0;
    localparam logic [TGT_W-1:0] SECURE_HI = 10'h0FF;
    localparam logic [TGT_W-1:0] TGT_NV_CFG = 10'h200;
    localparam logic [TGT_W-1:0] TGT_NV_DIVH = 10'h201;
    localparam logic [TGT_W-1:0] TGT_NV_DIVL = 10'h202;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // ==========================================================
    // field layout
    localparam int CFG_W = 5;
    localparam int GUARD_W = 4;
    localparam int CFG_SECURE_BIT = 4;
    localparam int DIVH_LOCK_BIT = 7;
    localparam int DIV_W = 11;
    localparam int DIVH_W = 3;
    localparam int CMD_OP_LSB = 12;
    localparam int CMD_DATA_LSB = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    // ==========================================================
    // timebase: software sets divisor = int(f_ref * 35e-6 + 0.5)
    localparam int TIMEBASE_US = 35;
    localparam int PE_TICKS_DEFAULT = 4;
    // ==========================================================
    // apb map
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] OFS_CFG_SHADOW = 12'h000;
    localparam logic [APB_AW-1:0] OFS_DIV_HIGH = 12'h004;
    localparam logic [APB_AW-1:0] OFS_DIV_LOW = 12'h008;
    localparam logic [APB_AW-1:0] OFS_NV_CFG = 12'h00C;
    localparam logic [APB_AW-1:0] OFS_NV_DIV_HIGH = 12'h010;
    localparam logic [APB_AW-1:0] OFS_NV_DIV_LOW = 12'h014;
    localparam logic [APB_AW-1:0] OFS_PE_CMD = 12'h018;
    localparam logic [APB_AW-1:0] OFS_PE_STATUS = 12'h01C;
    localparam logic [APB_AW-1:0] OFS_ARRAY_BASE = 12'h800;
    // ==========================================================
    // operations and states
    typedef enum logic [1:0] {
        OP_PROG = 2'h0,
        OP_ERASE_BYTE = 2'h1,
        OP_ERASE_BLOCK = 2'h2,
        OP_ERASE_BULK = 2'h3
    } eecp_op_e;
    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_WAIT = 2'h1,
        S_APPLY = 2'h3
    } eecp_state_e;
endpackage

// ===== common/eecp_tb_if.sv
// eecp_tb_if: link between the control logic and the timebase divider
`timescale 1ns/10ps
interface eecp_tb_if;
    logic ref_en;
    logic [eecp_pkg::DIV_W-1:0] divisor;
    logic tick;
    modport ctl (output ref_en, output divisor, input tick);
    modport div (input ref_en, input divisor, output tick);
endinterface

// ===== logic/eecp_timebase.sv
// eecp_timebase: divides the reference enable into the program/erase timebase
`timescale 1ns/10ps
module eecp_timebase (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // divider link
    eecp_tb_if.div tb
);
    import eecp_pkg::*;

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    // ==========================================================
    // counter
    // a zero divisor stalls the timebase rather than ticking every cycle
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (tb.ref_en && tb.divisor != '0) begin
            if (cnt_q + 1'b1 == tb.divisor) begin
                cnt_d = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tb.tick = tick_q;

    // ==========================================================
    // checks
    a_tick_wrap: assert property (@(posedge clk) disable iff (srst)
        tick_q |-> cnt_q == '0 && $past(cnt_q) + 1'b1 == $past(tb.divisor))
        else $error("timebase tick not at divisor wrap");
endmodule

// ===== logic/eecp_top.sv
// eecp_top: eeprom array configuration, timebase and protection logic
//
// Function
// - 512-byte array, programmed by internal sequence
// - reset copies nonvolatile config and divider
// - volatile copies read/write and define guards and divisor; arming uses nv bit 4
// - nonvolatile registers use the array mechanism
// - 35 us timebase from selectable reference
// - armed lock refuses secured 16-byte range
// - secured range still reads normally
// - armed lock freezes nonvolatile config register
// - armed lock refuses block and bulk erase
// - armed: unguarded byte operations still allowed
// - armed lock permanent, configuration frozen
// - four 128-byte blocks, each guard bit shields
// - guards reload at reset and nv read
// - programmed divisor lock reloads zero each reset
// - divisor lock refuses nv and volatile changes
// - config: lock bit 4, guards 3..0
// - divisor 11 bits, lock in high bit 7
`timescale 1ns/10ps
module eecp_top #(
    parameter int PE_TICKS = eecp_pkg::PE_TICKS_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [eecp_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timebase reference
    input wire logic timebase_ref_select,
    input wire logic crystal_ref_clock,
    // status
    output logic pe_busy,
    output logic timebase_tick
);
    import eecp_pkg::*;

    // ==========================================================
    // state
    logic [7:0] mem_q [ARRAY_BYTES] = '{default: ERASED_BYTE};
    // nonvolatile cells keep their value through reset
    logic [7:0] nv_cfg_q = ERASED_BYTE;
    logic [7:0] nv_cfg_d;
    logic [7:0] nv_divh_q = ERASED_BYTE;
    logic [7:0] nv_divh_d;
    logic [7:0] nv_divl_q = ERASED_BYTE;
    logic [7:0] nv_divl_d;
    logic [CFG_W-1:0] cfg_q;
    logic [CFG_W-1:0] cfg_d;
    logic lock_q;
    logic lock_d;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    eecp_state_e st_q;
    eecp_state_e st_d;
    logic [TGT_W-1:0] tgt_q;
    logic [TGT_W-1:0] tgt_d;
    eecp_op_e op_q;
    eecp_op_e op_d;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic [7:0] ticks_q;
    logic [7:0] ticks_d;
    logic refused_q;
    logic refused_d;
    logic done_q;
    logic done_d;
    logic xclk_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    // ==========================================================
    // timebase
    eecp_tb_if tb ();

    assign tb.ref_en = timebase_ref_select ? (crystal_ref_clock & ~xclk_q) : 1'b1;
    assign tb.divisor = div_q;

    eecp_timebase u_timebase (
        .clk(clk),
        .srst(srst),
        .tb(tb.div)
    );

    // reference edge detector; it copies the pin every cycle, so no false edge follows reset
    always_ff @(posedge clk) begin
        xclk_q <= crystal_ref_clock;
    end

    // ==========================================================
    // apb decode
    logic setup;
    logic access;
    logic in_array;
    logic mapped;
    logic writable;
    logic [8:0] arr_idx;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign in_array = paddr >= OFS_ARRAY_BASE;
    assign arr_idx = paddr[10:2];
    assign writable = paddr == OFS_CFG_SHADOW || paddr == OFS_DIV_HIGH
        || paddr == OFS_DIV_LOW || paddr == OFS_PE_CMD;
    assign mapped = paddr[1:0] == 2'h0 && (in_array || writable || paddr == OFS_NV_CFG
        || paddr == OFS_NV_DIV_HIGH || paddr == OFS_NV_DIV_LOW || paddr == OFS_PE_STATUS);
    assign pready = 1'b1;
    assign pslverr = access & (~mapped | (pwrite & ~writable));
    assign prdata = prdata_q;
    assign pe_busy = st_q != S_IDLE;
    assign timebase_tick = tb.tick;

    // ==========================================================
    // request check
    logic [TGT_W-1:0] n_tgt;
    eecp_op_e n_op;
    logic armed;
    logic n_arr;
    logic n_multi;
    logic n_secure;
    logic n_guarded;
    logic refuse;
    logic start;

    assign n_tgt = pwdata[TGT_W-1:0];
    assign n_op = eecp_op_e'(pwdata[CMD_OP_LSB +: 2]);
    assign armed = ~nv_cfg_q[CFG_SECURE_BIT];
    assign n_arr = n_tgt < TGT_W'(ARRAY_BYTES);
    assign n_multi = n_op == OP_ERASE_BLOCK || n_op == OP_ERASE_BULK;
    assign n_secure = n_tgt >= SECURE_LO && n_tgt <= SECURE_HI;
    // bulk crosses every block, so any guard stops it
    assign n_guarded = n_op == OP_ERASE_BULK ? |cfg_q[GUARD_W-1:0] : cfg_q[n_tgt[8:7]];
    assign start = access & pwrite & paddr == OFS_PE_CMD & st_q == S_IDLE;
    always_comb begin
        refuse = 1'b0;
        if (!n_arr && (n_tgt > TGT_NV_DIVL || n_multi)) refuse = 1'b1;
        if (n_arr && n_guarded) refuse = 1'b1;
        if (armed && n_arr && n_secure) refuse = 1'b1;
        if (armed && n_tgt == TGT_NV_CFG) refuse = 1'b1;
        if (armed && n_multi) refuse = 1'b1;
        if (!lock_q && (n_tgt == TGT_NV_DIVH || n_tgt == TGT_NV_DIVL)) refuse = 1'b1;
    end

    // ==========================================================
    // register and sequence next state
    function automatic logic [7:0] pe_byte(input eecp_op_e op, input logic [7:0] old, input logic [7:0] dat);
        pe_byte = op == OP_PROG ? (old & dat) : ERASED_BYTE;
    endfunction

    always_comb begin
        cfg_d = cfg_q;
        lock_d = lock_q;
        div_d = div_q;
        st_d = st_q;
        tgt_d = tgt_q;
        op_d = op_q;
        data_d = data_q;
        ticks_d = ticks_q;
        refused_d = refused_q;
        done_d = done_q;
        nv_cfg_d = nv_cfg_q;
        nv_divh_d = nv_divh_q;
        nv_divl_d = nv_divl_q;
        if (access && pwrite) begin
            if (paddr == OFS_CFG_SHADOW && !armed) cfg_d = pwdata[CFG_W-1:0];
            if (paddr == OFS_DIV_HIGH && lock_q) begin
                lock_d = pwdata[DIVH_LOCK_BIT];
                div_d[DIV_W-1:8] = pwdata[DIVH_W-1:0];
            end
            if (paddr == OFS_DIV_LOW && lock_q) div_d[7:0] = pwdata[7:0];
        end
        if (access && !pwrite && paddr == OFS_NV_CFG) cfg_d = nv_cfg_q[CFG_W-1:0];
        case (st_q)
            S_IDLE: begin
                if (start) begin
                    refused_d = refuse;
                    done_d = 1'b0;
                    if (!refuse) begin
                        st_d = S_WAIT;
                        tgt_d = n_tgt;
                        op_d = n_op;
                        data_d = pwdata[CMD_DATA_LSB +: 8];
                        ticks_d = '0;
                    end
                end
            end
            S_WAIT: begin
                if (tb.tick) begin
                    ticks_d = ticks_q + 1'b1;
                    if (ticks_q == 8'(PE_TICKS - 1)) st_d = S_APPLY;
                end
            end
            S_APPLY: begin
                st_d = S_IDLE;
                done_d = 1'b1;
                if (tgt_q == TGT_NV_CFG) nv_cfg_d = pe_byte(op_q, nv_cfg_q, data_q);
                if (tgt_q == TGT_NV_DIVH) nv_divh_d = pe_byte(op_q, nv_divh_q, data_q);
                if (tgt_q == TGT_NV_DIVL) nv_divl_d = pe_byte(op_q, nv_divl_q, data_q);
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_q <= nv_cfg_q[CFG_W-1:0];
            lock_q <= nv_divh_q[DIVH_LOCK_BIT];
            div_q <= {nv_divh_q[DIVH_W-1:0], nv_divl_q};
            st_q <= S_IDLE;
            tgt_q <= '0;
            op_q <= OP_PROG;
            data_q <= '0;
            ticks_q <= '0;
            refused_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            lock_q <= lock_d;
            div_q <= div_d;
            st_q <= st_d;
            tgt_q <= tgt_d;
            op_q <= op_d;
            data_q <= data_d;
            ticks_q <= ticks_d;
            refused_q <= refused_d;
            done_q <= done_d;
        end
    end

    // programming in flight survives reset only in the cells, never half-applied
    always_ff @(posedge clk) begin
        nv_cfg_q <= srst ? nv_cfg_q : nv_cfg_d;
        nv_divh_q <= srst ? nv_divh_q : nv_divh_d;
        nv_divl_q <= srst ? nv_divl_q : nv_divl_d;
    end

    // ==========================================================
    // array cells
    always_ff @(posedge clk) begin
        if (!srst && st_q == S_APPLY && tgt_q < TGT_W'(ARRAY_BYTES)) begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
                if (op_q == OP_ERASE_BULK) begin
                    mem_q[i] <= ERASED_BYTE;
                end else if (op_q == OP_ERASE_BLOCK && 2'(i / BLOCK_BYTES) == tgt_q[8:7]) begin
                    mem_q[i] <= ERASED_BYTE;
                end else if (TGT_W'(i) == tgt_q && !(op_q == OP_ERASE_BLOCK)) begin
                    mem_q[i] <= pe_byte(op_q, mem_q[i], data_q);
                end
            end
        end
    end

    // ==========================================================
    // read data, captured in the setup phase for a zero-wait access
    always_comb begin
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = '0;
            if (in_array) prdata_d[7:0] = mem_q[arr_idx];
            else begin
                case (paddr)
                    OFS_CFG_SHADOW: prdata_d[CFG_W-1:0] = cfg_q;
                    OFS_DIV_HIGH: prdata_d[7:0] = {lock_q, 4'h0, div_q[DIV_W-1:8]};
                    OFS_DIV_LOW: prdata_d[7:0] = div_q[7:0];
                    OFS_NV_CFG: prdata_d[7:0] = nv_cfg_q;
                    OFS_NV_DIV_HIGH: prdata_d[7:0] = nv_divh_q;
                    OFS_NV_DIV_LOW: prdata_d[7:0] = nv_divl_q;
                    OFS_PE_STATUS: begin
                        prdata_d[STAT_BUSY_BIT] = st_q != S_IDLE;
                        prdata_d[STAT_REFUSED_BIT] = refused_q;
                        prdata_d[STAT_DONE_BIT] = done_q;
                    end
                    default: prdata_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) prdata_q <= '0;
        else prdata_q <= prdata_d;
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_refused_start;
        start && refuse;
    endsequence
    sequence s_left_idle;
        st_q == S_IDLE && refused_q && !done_q;
    endsequence

    a_refuse_no_seq: assert property (s_refused_start |=> s_left_idle ##1 st_q == S_IDLE)
        else $error("refused request started a sequence");
    a_reset_copy: assert property ($fell(srst) |-> cfg_q == $past(nv_cfg_q[CFG_W-1:0])
        && div_q == $past({nv_divh_q[DIVH_W-1:0], nv_divl_q}))
        else $error("reset did not copy nonvolatile settings");
    a_lock_reload: assert property ($fell(srst) && !$past(nv_divh_q[DIVH_LOCK_BIT]) |-> !lock_q)
        else $error("divisor lock not reloaded");
    a_div_locked: assert property (!lock_q |=> !lock_q && $stable(div_q))
        else $error("locked divisor changed");
    a_secure_guard: assert property (start && armed && n_arr && n_secure |=> st_q == S_IDLE)
        else $error("secured range accepted while armed");
    a_multi_armed: assert property (start && armed && n_multi |=> st_q == S_IDLE)
        else $error("block or bulk erase accepted while armed");
    a_block_guard: assert property (start && n_arr && cfg_q[n_tgt[8:7]] |=> refused_q)
        else $error("guarded block accepted");
    a_nv_frozen: assert property (armed |=> nv_cfg_q == $past(nv_cfg_q) && armed)
        else $error("armed configuration changed");
    a_nv_read_reload: assert property (access && !pwrite && paddr == OFS_NV_CFG
        |=> cfg_q == $past(nv_cfg_q[CFG_W-1:0]))
        else $error("guards not reloaded on nonvolatile read");
    a_apply_after_ticks: assert property (st_q == S_WAIT && tb.tick && ticks_q == 8'(PE_TICKS - 1)
        |=> st_q == S_APPLY ##1 st_q == S_IDLE && done_q)
        else $error("sequence did not finish after timebase ticks");
endmodule

// ===== verification/eecp_testbench.sv
// eecp testbench: apb-driven checks of configuration, timebase and protection
`timescale 1ns/10ps
module testbench;
    import eecp_pkg::*;
    // ==========================================================
    // signals and design
    localparam int TICKS = 2;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ref_sel = 1'b0;
    logic xtal = 1'b0;
    logic pe_busy;
    logic timebase_tick;
    logic [31:0] rdat;
    logic rerr;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;

    eecp_top #(.PE_TICKS(TICKS)) dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timebase_ref_select(ref_sel), .crystal_ref_clock(xtal),
        .pe_busy(pe_busy), .timebase_tick(timebase_tick));

    always #5 clk = ~clk;
    // crystal reference rises every second clock
    always @(posedge clk) xtal <= ~xtal;

    // ==========================================================
    // helpers
    task automatic end_sim;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard: whole run is under three thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // idle edge first, so release and next setup never share a time step
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e = 1'b0);
        xfer(a, 1'b1, d);
        chk({31'h0, rerr}, {31'h0, e});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF,
                      input logic e = 1'b0);
        xfer(a, 1'b0, 32'h0);
        chk(rdat & m, exp);
        chk({31'h0, rerr}, {31'h0, e});
    endtask

    function automatic logic [11:0] arr(input int i);
        return OFS_ARRAY_BASE + 12'(i * 4);
    endfunction

    // issue one command, wait out the sequence, judge the status word
    task automatic pe(input eecp_op_e op, input logic [9:0] tgt, input logic [7:0] d, input logic ok);
        wr(OFS_PE_CMD, {8'h00, d, 2'b00, op, 2'b00, tgt});
        // busy is sampled mid-cycle, away from the edge that moves it
        @(negedge clk);
        chk({31'h0, pe_busy}, {31'h0, ok});
        while (pe_busy !== 1'b0) @(negedge clk);
        rd(OFS_PE_STATUS, ok ? 32'h4 : 32'h2);
    endtask

    task automatic gap(input int exp);
        int n;
        n = 0;
        @(negedge clk);
        while (timebase_tick !== 1'b1) @(negedge clk);
        @(negedge clk);
        while (timebase_tick !== 1'b1) begin
            n++;
            @(negedge clk);
        end
        chk(32'(n + 1), 32'(exp));
        @(posedge clk);
    endtask

    task automatic do_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset_vals;
        rd(OFS_CFG_SHADOW, 32'h1F);
        rd(OFS_DIV_HIGH, 32'h87);
        rd(OFS_DIV_LOW, 32'hFF);
        rd(OFS_NV_CFG, 32'h1F, 32'h1F);
        rd(arr(511), 32'hFF);
        rd(12'h020, 32'h0, 32'h0, 1'b1);
        rd(12'h002, 32'h0, 32'h0, 1'b1);
        wr(OFS_NV_CFG, 32'h0, 1'b1);
        wr(arr(0), 32'h0, 1'b1);
    endtask

    task automatic t_timebase;
        wr(OFS_DIV_LOW, 32'h03);
        wr(OFS_DIV_HIGH, 32'h80);
        rd(OFS_DIV_HIGH, 32'h80);
        rd(OFS_DIV_LOW, 32'h03);
        gap(3);
        ref_sel <= 1'b1;
        gap(6);
        ref_sel <= 1'b0;
    endtask

    task automatic t_program;
        wr(OFS_CFG_SHADOW, 32'h10);
        rd(OFS_CFG_SHADOW, 32'h10);
        pe(OP_PROG, 10'h005, 8'hA5, 1'b1);
        rd(arr(5), 32'hA5);
        pe(OP_PROG, 10'h005, 8'h0F, 1'b1);
        rd(arr(5), 32'h05);
        pe(OP_ERASE_BYTE, 10'h005, 8'h00, 1'b1);
        rd(arr(5), 32'hFF);
        pe(OP_PROG, 10'h100, 8'h3C, 1'b1);
        pe(OP_PROG, 10'h180, 8'h22, 1'b1);
        pe(OP_ERASE_BLOCK, 10'h140, 8'h00, 1'b1);
        rd(arr(256), 32'hFF);
        rd(arr(384), 32'h22);
        pe(OP_ERASE_BULK, 10'h000, 8'h00, 1'b1);
        rd(arr(384), 32'hFF);
        pe(OP_PROG, 10'h203, 8'h00, 1'b0);
    endtask

    // the accepted byte sits apart from the refused one, so a later pass still finds it erased
    task automatic t_guards;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CFG_SHADOW, 32'h10 | (32'h1 << i));
            pe(OP_PROG, 10'(i * 128 + 7), 8'h00, 1'b0);
            rd(arr(i * 128 + 7), 32'hFF);
            pe(OP_PROG, 10'(((i + 1) % 4) * 128 + 8), 8'hFE, 1'b1);
            rd(arr(((i + 1) % 4) * 128 + 8), 32'hFE);
            pe(OP_ERASE_BULK, 10'h000, 8'h00, 1'b0);
        end
    endtask

    task automatic t_nv_reload;
        pe(OP_PROG, TGT_NV_CFG, 8'hF0, 1'b1);
        rd(OFS_NV_CFG, 32'h10, 32'h1F);
        rd(OFS_CFG_SHADOW, 32'h10);
        pe(OP_PROG, 10'h1F0, 8'h00, 1'b1);
    endtask

    task automatic t_div_lock;
        pe(OP_PROG, TGT_NV_DIVL, 8'h03, 1'b1);
        pe(OP_PROG, TGT_NV_DIVH, 8'h78, 1'b1);
        rd(OFS_NV_DIV_HIGH, 32'h00, 32'h87);
        rd(OFS_DIV_HIGH, 32'h80);
        do_reset();
        rd(OFS_DIV_HIGH, 32'h00);
        rd(OFS_DIV_LOW, 32'h03);
        rd(OFS_CFG_SHADOW, 32'h10);
        wr(OFS_DIV_LOW, 32'h05);
        wr(OFS_DIV_HIGH, 32'h81);
        rd(OFS_DIV_LOW, 32'h03);
        rd(OFS_DIV_HIGH, 32'h00);
        pe(OP_ERASE_BYTE, TGT_NV_DIVH, 8'h00, 1'b0);
        pe(OP_PROG, TGT_NV_DIVL, 8'h01, 1'b0);
        gap(3);
    endtask

    task automatic t_arm;
        pe(OP_PROG, 10'h0F5, 8'h3C, 1'b1);
        pe(OP_PROG, TGT_NV_CFG, 8'hEF, 1'b1);
        pe(OP_PROG, 10'h0F0, 8'h00, 1'b0);
        pe(OP_ERASE_BYTE, 10'h0FF, 8'h00, 1'b0);
        rd(arr(245), 32'h3C);
        pe(OP_ERASE_BYTE, TGT_NV_CFG, 8'h00, 1'b0);
        pe(OP_ERASE_BLOCK, 10'h100, 8'h00, 1'b0);
        pe(OP_ERASE_BULK, 10'h000, 8'h00, 1'b0);
        pe(OP_PROG, 10'h0EF, 8'h5A, 1'b1);
        rd(arr(239), 32'h5A);
        pe(OP_PROG, 10'h101, 8'h5A, 1'b1);
        wr(OFS_CFG_SHADOW, 32'h1F);
        rd(OFS_CFG_SHADOW, 32'h10);
        do_reset();
        rd(OFS_CFG_SHADOW, 32'h00);
        rd(OFS_DIV_HIGH, 32'h00);
        pe(OP_PROG, 10'h0F1, 8'h00, 1'b0);
    endtask

    // ==========================================================
    // main sequence; arming is permanent, so it runs last
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_reset_vals();
        t_timebase();
        t_program();
        t_guards();
        t_nv_reload();
        t_div_lock();
        t_arm();
        end_sim();
    end
endmodule
